// *** logic/hold_timer.v ***
`timescale 1ns/1ps
// counts cycles a level stays high; flags once the count is reached
module hold_timer #(
    parameter CYCLES = 200,
    parameter W = 16
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // level to time and result
    input wire level,
    output reg reached_ff
);
    // limit cut to the counter width on purpose
    localparam integer LIMIT_I = CYCLES - 1;
    localparam [W-1:0] LIMIT = LIMIT_I[W-1:0];
    reg [W-1:0] cnt_ff;

    // a drop of the level restarts the count, so glitches never accumulate
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= {W{1'b0}};
            reached_ff <= 1'b0;
        end else if (!level) begin
            cnt_ff <= {W{1'b0}};
            reached_ff <= 1'b0;
        end else if (cnt_ff >= LIMIT) begin
            reached_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// *** logic/module_power_reset_handshake.v ***
// How it works
// - carrier drives on/off request high for on, low for off
// - reset line held low by carrier keeps the module in reset
// - reset line released only after internal power-up sequence completes
// - shutdown request is open drain, pulled low to ask for shutdown
// - sleep indicator low while in deep sleep, high otherwise
// - sleep/wake input is a plain input software may use
// - variant strap is a static level readable by the carrier
// - reset holds processor system and onboard storage in reset
// - controller takes power requests and sequences rail changes
// - any enabled wake event brings the system out of deep sleep
// - in sleep, logic states held and idle domains gated
// - on/off request low for 10 us starts the shutdown sequence
`timescale 1ns/1ps
`include "pwr_seq_defs.vh"
module module_power_reset_handshake #(
    parameter PWRUP_CYCLES = `PWRUP_CYC,
    parameter NWAKE = `WAKE_SRCS,
    parameter NREQ = `PREQ_SRCS
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // carrier sideband pins
    input wire power_on_req,
    input wire system_reset_n_in,
    output reg system_reset_n_out,
    output reg system_reset_n_oe,
    output reg shutdown_req_n_out,
    output reg shutdown_req_n_oe,
    output reg sleep_indicator_n,
    input wire sleep_wake_in,
    input wire recovery_strap_n,
    input wire variant_strap,
    output reg variant_strap_out,
    // internal resets and boot mode
    output reg cpu_reset_n,
    output reg storage_reset_n,
    output reg recovery_boot,
    // software and event side
    input wire sw_shutdown,
    input wire thermal_shutdown,
    input wire sleep_enter,
    output reg sleep_wake_level,
    input wire [NWAKE-1:0] wake_event,
    input wire [NWAKE-1:0] wake_enable,
    input wire [NREQ-1:0] pwr_req,
    // rail control
    output reg [NREQ-1:0] rail_enable,
    output reg [NREQ-1:0] domain_gate,
    output reg state_hold
);
    localparam ST_OFF = 5'b00001;
    localparam ST_PWRUP = 5'b00010;
    localparam ST_ON = 5'b00100;
    localparam ST_SLEEP = 5'b01000;
    localparam ST_PWRDN = 5'b10000;
    localparam PW = 16;
    localparam integer PWRUP_LAST_I = PWRUP_CYCLES - 1;
    localparam [PW-1:0] PWRUP_LAST = PWRUP_LAST_I[PW-1:0];
    // synchroniser reset levels: sleep/wake idles high, the rest low
    localparam [2:0] SYNC_RST = 3'b100;

    // true while the rails are up; shared by pin and reset outputs
    function powered;
        input [4:0] st;
        begin
            powered = (st == ST_ON) || (st == ST_SLEEP);
        end
    endfunction

    wire on_s;
    wire rst_line_s;
    wire sw_s;
    wire off_long;
    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [PW-1:0] seq_cnt_ff;
    reg rst_line_d_ff;
    reg on_d_ff;
    wire wake_any;
    wire [2:0] sync_in;
    wire [2:0] sync_out;
    genvar gi;

    // pins are level inputs; sync before use
    // bit 0 on request, bit 1 reset line, bit 2 sleep/wake
    assign sync_in = {sleep_wake_in, system_reset_n_in, power_on_req};
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            sync2 #(.RST_VAL(SYNC_RST[gi])) u_sync (
                .mclk(mclk),
                .rst_b(rst_b),
                .din(sync_in[gi]),
                .dout(sync_out[gi])
            );
        end
    endgenerate
    assign on_s = sync_out[0];
    assign rst_line_s = sync_out[1];
    assign sw_s = sync_out[2];

    // low on/off request must persist before shutdown
    hold_timer #(.CYCLES(`OFF_HOLD_CYC), .W(PW)) u_off_hold (
        .mclk(mclk),
        .rst_b(rst_b),
        .level(~on_s),
        .reached_ff(off_long)
    );

    // only enabled wake sources count
    assign wake_any = |(wake_event & wake_enable);

    // edge history for reset rise and on request
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_line_d_ff <= 1'b0;
            on_d_ff <= 1'b0;
        end else begin
            rst_line_d_ff <= rst_line_s;
            on_d_ff <= on_s;
        end
    end

    // power state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (on_s && !on_d_ff) // rising request turns on
                    nxt_state = ST_PWRUP;
            end
            ST_PWRUP: begin
                if (!on_s)
                    nxt_state = ST_OFF;
                else if (seq_cnt_ff >= PWRUP_LAST)
                    nxt_state = ST_ON;
            end
            ST_ON: begin
                if (off_long)
                    nxt_state = ST_PWRDN;
                else if (sleep_enter)
                    nxt_state = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (off_long)
                    nxt_state = ST_PWRDN;
                else if (wake_any)
                    nxt_state = ST_ON;
            end
            ST_PWRDN: begin
                nxt_state = ST_OFF;
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    // state and power-up sequence counter
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_OFF;
            seq_cnt_ff <= {PW{1'b0}};
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_PWRUP)
                seq_cnt_ff <= seq_cnt_ff + {{(PW-1){1'b0}}, 1'b1};
            else
                seq_cnt_ff <= {PW{1'b0}};
        end
    end

    // pin and internal outputs, all registered
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            system_reset_n_out <= 1'b0;
            system_reset_n_oe <= 1'b1;
            shutdown_req_n_out <= 1'b0;
            shutdown_req_n_oe <= 1'b0;
            sleep_indicator_n <= 1'b1;
            variant_strap_out <= 1'b0;
            cpu_reset_n <= 1'b0;
            storage_reset_n <= 1'b0;
            recovery_boot <= 1'b0;
            sleep_wake_level <= 1'b1;
            rail_enable <= {NREQ{1'b0}};
            domain_gate <= {NREQ{1'b0}};
            state_hold <= 1'b0;
        end else begin
            // hold line low until power-up completes, then release
            system_reset_n_out <= 1'b0;
            system_reset_n_oe <= !powered(state_ff);
            // pull low only to request; released otherwise
            shutdown_req_n_out <= 1'b0;
            shutdown_req_n_oe <= (sw_shutdown || thermal_shutdown) &&
                                 powered(state_ff);
            sleep_indicator_n <= !(state_ff == ST_SLEEP);
            variant_strap_out <= variant_strap;
            // a low line from either side resets both targets
            cpu_reset_n <= rst_line_s && powered(state_ff);
            storage_reset_n <= rst_line_s && powered(state_ff);
            // strap caught on the line's rising edge only
            if (rst_line_s && !rst_line_d_ff)
                recovery_boot <= !recovery_strap_n;
            sleep_wake_level <= sw_s; // plain input for software
            // rails follow requests while on; held in sleep, cut in the other states
            if (state_ff == ST_ON)
                rail_enable <= pwr_req;
            else if (state_ff != ST_SLEEP)
                rail_enable <= {NREQ{1'b0}};
            // gate idle domains in sleep, hold logic states
            domain_gate <= (state_ff == ST_SLEEP) ? ~pwr_req :
                           {NREQ{1'b0}};
            state_hold <= (state_ff == ST_SLEEP);
        end
    end
endmodule

// *** logic/pwr_seq_defs.vh ***
`ifndef PWR_SEQ_DEFS_VH
`define PWR_SEQ_DEFS_VH

// clock rate in kHz
`define MCLK_KHZ 20000
// least low time of the on/off request before shutdown, in ns
`define OFF_HOLD_NS 10000
// cycles for the off hold, rounded up
`define OFF_HOLD_CYC ((`OFF_HOLD_NS * `MCLK_KHZ + 999999) / 1000000)
// default power-up sequence length in cycles
`define PWRUP_CYC 64
// number of wake sources
`define WAKE_SRCS 4
// number of power request sources
`define PREQ_SRCS 4

`endif

// *** logic/sync2.v ***
`timescale 1ns/1ps
// two-stage level synchroniser with a reset value
module sync2 #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // level in and out
    input wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // first stage feeds only the second stage
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

// *** verification/carrier_model.sv ***
`timescale 1ns/1ps
// carrier board: on request, supplies and the pulled-up lines
module carrier_model (
    // clock and bench controls
    input wire mclk,
    input wire want_on,
    input wire carrier_rst_n,
    // device pull-down enables
    input wire rst_oe,
    input wire shdn_oe,
    // resolved lines and supply state
    output reg power_on_req,
    output wire reset_wire,
    output wire shdn_wire,
    output reg supply_on
);
    // pull-ups: a released line reads high
    assign reset_wire = carrier_rst_n & ~rst_oe;
    assign shdn_wire = ~shdn_oe;
    reg on_q;
    initial on_q = 1'b0;
    initial power_on_req = 1'b0;
    initial supply_on = 1'b0;
    // sample on the rising edge so bench and device changes never race;
    // drop the on request as soon as shutdown is asked for
    always @(posedge mclk) begin
        on_q <= want_on & shdn_wire;
        supply_on <= power_on_req & reset_wire;
    end
    // the request pin moves on the falling edge, like the bench-driven inputs
    always @(negedge mclk)
        power_on_req <= on_q;
endmodule

// *** verification/pwr_seq_props.sv ***
`timescale 1ns/1ps
// pin relations of the power and reset handshake
module pwr_seq_props #(
    parameter PWRUP_CYCLES = 64,
    parameter NWAKE = 4
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // carrier pins
    input wire power_on_req,
    input wire system_reset_n_in,
    input wire system_reset_n_oe,
    input wire shutdown_req_n_oe,
    input wire sleep_indicator_n,
    input wire recovery_strap_n,
    // internal side
    input wire cpu_reset_n,
    input wire storage_reset_n,
    input wire recovery_boot,
    input wire sw_shutdown,
    input wire thermal_shutdown,
    input wire sleep_enter,
    input wire [NWAKE-1:0] wake_event,
    input wire [NWAKE-1:0] wake_enable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // asleep, an enabled wake present and no sleep request pending
    sequence s_wake;
        !sleep_indicator_n && |(wake_event & wake_enable) && !sleep_enter;
    endsequence
    // the line has been low long enough to pass the synchroniser
    sequence s_line_low;
        !system_reset_n_in [*5];
    endsequence
    AST_RST_HOLD: assert property (
        s_line_low |-> !cpu_reset_n && !storage_reset_n)
        else $error("internal reset free while line low");
    AST_RST_REL: assert property (
        $fell(system_reset_n_oe) |-> $past(power_on_req, PWRUP_CYCLES))
        else $error("line released before power-up ran");
    AST_ON_SYNC: assert property (
        $rose(power_on_req) && system_reset_n_oe |-> system_reset_n_oe [*3])
        else $error("on request acted on too early");
    AST_RECOV: assert property (
        $rose(cpu_reset_n) |-> ##[0:2] recovery_boot == !recovery_strap_n)
        else $error("boot mode not taken from strap");
    AST_SHDN: assert property (
        shutdown_req_n_oe |-> $past(sw_shutdown | thermal_shutdown))
        else $error("shutdown pulled with no cause");
    AST_SLEEP_IND: assert property (
        $fell(sleep_indicator_n) |-> $past(sleep_enter, 2))
        else $error("indicator low without sleep request");
    AST_WAKE: assert property (
        s_wake |-> ##[1:3] sleep_indicator_n)
        else $error("enabled wake ignored");
    AST_OFF_HOLD: assert property (
        $rose(system_reset_n_oe) |->
        !$past(power_on_req, 200) && !$past(power_on_req, 2))
        else $error("shutdown without full off hold");
endmodule

bind module_power_reset_handshake pwr_seq_props #(
    .PWRUP_CYCLES(PWRUP_CYCLES),
    .NWAKE(NWAKE)
) u_props (
    .mclk(mclk),
    .rst_b(rst_b),
    .power_on_req(power_on_req),
    .system_reset_n_in(system_reset_n_in),
    .system_reset_n_oe(system_reset_n_oe),
    .shutdown_req_n_oe(shutdown_req_n_oe),
    .sleep_indicator_n(sleep_indicator_n),
    .recovery_strap_n(recovery_strap_n),
    .cpu_reset_n(cpu_reset_n),
    .storage_reset_n(storage_reset_n),
    .recovery_boot(recovery_boot),
    .sw_shutdown(sw_shutdown),
    .thermal_shutdown(thermal_shutdown),
    .sleep_enter(sleep_enter),
    .wake_event(wake_event),
    .wake_enable(wake_enable)
);

// *** verification/tb.sv ***
`timescale 1ns/1ps
// bench for the power and reset handshake
module tb;
    logic mclk = 0, rst_b = 0, want_on = 0, carrier_rst_n = 1;
    logic sleep_wake_in = 0, recovery_strap_n = 1, variant_strap = 1;
    logic sw_shutdown = 0, thermal_shutdown = 0, sleep_enter = 0;
    logic [3:0] wake_event = 4'h0, wake_enable = 4'h0, pwr_req = 4'h5;
    wire on_req, rst_wire, shdn_wire, rst_oe, shdn_oe, ind_n, var_out;
    wire cpu_n, sto_n, rec_boot, sw_level;
    wire supply, hold, rst_out, shdn_out;
    wire [3:0] rails, gates;
    int error_cnt = 0, cmp_count = 0, i, k;
    // rows: wake event, wake enable, indicator after the attempt
    logic [8:0] rows [5] = '{9'h05a, 9'h023, 9'h045, 9'h089, 9'h111};
    initial forever #25 mclk = ~mclk;
    carrier_model u_carrier (.mclk(mclk), .want_on(want_on),
        .carrier_rst_n(carrier_rst_n), .rst_oe(rst_oe), .shdn_oe(shdn_oe),
        .power_on_req(on_req), .reset_wire(rst_wire),
        .shdn_wire(shdn_wire), .supply_on(supply));
    // short power-up keeps the run brief
    module_power_reset_handshake #(.PWRUP_CYCLES(4)) dut (.mclk(mclk),
        .rst_b(rst_b), .power_on_req(on_req),
        .system_reset_n_in(rst_wire), .system_reset_n_out(rst_out),
        .system_reset_n_oe(rst_oe), .shutdown_req_n_out(shdn_out),
        .shutdown_req_n_oe(shdn_oe), .sleep_indicator_n(ind_n),
        .sleep_wake_in(sleep_wake_in), .recovery_strap_n(recovery_strap_n),
        .variant_strap(variant_strap), .variant_strap_out(var_out),
        .cpu_reset_n(cpu_n), .storage_reset_n(sto_n),
        .recovery_boot(rec_boot), .sw_shutdown(sw_shutdown),
        .thermal_shutdown(thermal_shutdown), .sleep_enter(sleep_enter),
        .sleep_wake_level(sw_level), .wake_event(wake_event),
        .wake_enable(wake_enable), .pwr_req(pwr_req), .rail_enable(rails),
        .domain_gate(gates), .state_hold(hold));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // bounded wait for a watched line; running out ends the run
    task wait_for(input int sel, input logic v);
        logic s;
        repeat (400) begin
            @(negedge mclk);
            s = sel == 0 ? ind_n : sel == 1 ? cpu_n : sel == 2 ? shdn_wire
                : rst_oe;
            if (s === v) return;
        end
        check(4'h0, 4'hf);
        wrap_up();
    endtask
    task power_up(input logic strap);
        recovery_strap_n = strap;
        want_on = 1'b1;
        // request is up but the line is still held: supplies stay off
        cyc(4);
        check({supply, rst_oe}, 2'b01);
        wait_for(1, 1'b1);
        check({rst_oe, rec_boot, sto_n}, {2'b00, !strap, 1'b1});
        check(supply, 1'b1);
    endtask
    initial begin
        cyc(12);
        check({rst_oe, shdn_oe, ind_n, cpu_n}, 4'ha);
        rst_b = 1'b1;
        cyc(20);
        check({rst_oe, rails, var_out, sw_level}, 7'h42);
        check(supply, 1'b0);
        power_up(1'b0);
        variant_strap = 1'b0;
        sleep_wake_in = 1'b1;
        cyc(4);
        check({rails, var_out, sw_level}, {pwr_req, 2'b01});
        // rails follow a changed request while on
        pwr_req = 4'h9;
        cyc(2);
        check(rails, 4'h9);
        // carrier holds the line low: module stays in reset
        carrier_rst_n = 1'b0;
        cyc(6);
        check({cpu_n, sto_n}, 2'b00);
        carrier_rst_n = 1'b1;
        wait_for(1, 1'b1);
        // off glitch shorter than the hold time changes nothing
        want_on = 1'b0;
        cyc(150);
        want_on = 1'b1;
        cyc(10);
        check({rst_oe, cpu_n}, 2'b01);
        for (i = 0; i < 5; i++) begin
            sleep_enter = 1'b1;
            wait_for(0, 1'b0);
            sleep_enter = 1'b0;
            check({hold, gates}, {1'b1, ~pwr_req});
            {wake_event, wake_enable} = rows[i][8:1];
            cyc(4);
            check(ind_n, rows[i][0]);
            wake_event = 4'h0;
        end
        // mid-run reset: outputs fall back at once, then power returns
        rst_b = 1'b0;
        cyc(2);
        check({rst_oe, shdn_oe, ind_n, cpu_n, rails}, 8'ha0);
        check({hold, gates, rec_boot, sto_n}, 7'h00);
        rst_b = 1'b1;
        wait_for(1, 1'b1);
        check({rst_oe, rec_boot, rails}, {2'b01, pwr_req});
        // each shutdown source: carrier drops power, module goes off
        for (k = 0; k < 2; k++) begin
            {sw_shutdown, thermal_shutdown} = k ? 2'b01 : 2'b10;
            wait_for(2, 1'b0);
            want_on = 1'b0;
            {sw_shutdown, thermal_shutdown} = 2'b00;
            wait_for(3, 1'b1);
            cyc(5);
            check({cpu_n, shdn_oe}, 2'b00);
            check({rst_out, shdn_out, rails, supply}, 7'h00);
            power_up(1'b1);
        end
        wrap_up();
    end
endmodule
